// ### ecpr_cfg.svh
`ifndef ECPR_CFG_SVH
`define ECPR_CFG_SVH

// Register byte addresses
`define ECPR_OFF_CONFIG_CONTROL 12'h000
`define ECPR_OFF_HANDLER_PRIORITY_ONE 12'h004
`define ECPR_OFF_HANDLER_PRIORITY_TWO 12'h008
`define ECPR_OFF_HANDLER_PRIORITY_THREE 12'h00C

// Config control bit positions
`define ECPR_BIT_STACK_ALIGN 9
`define ECPR_BIT_BUS_FAULT_IGNORE 8
`define ECPR_BIT_DIV_ZERO_TRAP 4
`define ECPR_BIT_UNALIGNED_TRAP 3
`define ECPR_BIT_UNPRIV_SWTRIG 1
`define ECPR_BIT_THREAD_ANY_LEVEL 0

// Writable bit masks; everything else is reserved
`define ECPR_MASK_CONFIG_CONTROL 32'h0000031B
`define ECPR_MASK_PRIORITY_ONE 32'h00FFFFFF
`define ECPR_MASK_PRIORITY_TWO 32'hFF000000
`define ECPR_MASK_PRIORITY_THREE 32'hFFFF0000

// Reset values
`define ECPR_RST_CONFIG_CONTROL 32'h00000200
`define ECPR_RST_PRIORITY 32'h00000000

// Priority field geometry
`define ECPR_PRI_FIELD_BITS 8
`define ECPR_PRI_IMPL_BITS 8
`define ECPR_PRI_MEM_LSB 0
`define ECPR_PRI_BUS_LSB 8
`define ECPR_PRI_USAGE_LSB 16
`define ECPR_PRI_SVC_LSB 24
`define ECPR_PRI_PEND_LSB 16
`define ECPR_PRI_TICK_LSB 24

// Access size codes on the core side
`define ECPR_SIZE_BYTE 2'h0
`define ECPR_SIZE_HALF 2'h1
`define ECPR_SIZE_WORD 2'h2

`endif

// ### ecpr_pkg.sv
package ecpr_pkg;

  typedef enum logic [2:0] {
    ECPR_SEL_NONE,
    ECPR_SEL_CONFIG_CONTROL,
    ECPR_SEL_PRIORITY_ONE,
    ECPR_SEL_PRIORITY_TWO,
    ECPR_SEL_PRIORITY_THREE
  } ecpr_sel_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] config_control;
    logic [31:0] handler_priority_one;
    logic [31:0] handler_priority_two;
    logic [31:0] handler_priority_three;
    logic entry_pad;
    logic stacked_align_bit;
    logic return_pad;
    logic fault_ignored;
    logic bus_fault_b_raise;
    logic lockup;
    logic div_trap;
    logic div_zero_result;
    logic unaligned_fault;
    logic swtrig_permit;
    logic swtrig_deny;
    logic thread_ok;
    logic thread_fault;
  } ecpr_state_t;

endpackage : ecpr_pkg

// ### ecpr_regs.sv
// What this block does
// - Stack align bit 9 picks 4-byte (0) or 8-byte (1) entry alignment.
// - Entry records applied padding in stacked status bit 9; return restores from it.
// - Bus fault ignore bit 8 set: priority -1/-2 handlers ignore data bus faults.
// - Bus fault ignore clear: such a fault at priority -1/-2 locks the core up.
// - Divide trap bit 4 set: divide with zero divisor traps.
// - Divide trap bit clear: divide by zero completes with quotient zero.
// - Unaligned trap bit 3 set: unaligned halfword/word access raises usage fault.
// - Unaligned multiple and doubleword transfers always fault.
// - Bit 1 permits (1) or blocks (0) unprivileged software trigger access.
// - Bit 0: thread mode entry only with no active exception, or from any level.
// - Three priority registers hold levels 0 to 255 per configurable exception.
// - Priority registers accept byte writes as well as word writes.
// - Register one: usage 23:16, bus 15:8, memory management 7:0, top byte reserved.
// - Register two: supervisor call priority 31:24, rest reserved.
// - Register three: tick 31:24, pendable service 23:16, low half reserved.
// - Config control bits 31:10, 7:5 and 2 are reserved.
// - Unimplemented low priority bits read as zero.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "ecpr_cfg.svh"

module ecpr_regs
  import ecpr_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic [31:0] prdata, // APB read data
  input wire logic exc_entry, // Exception entry pulse
  input wire logic entry_sp_bit2, // Bit 2 of stack pointer at entry
  input wire logic exception_return_value, // Exception return pulse
  input wire logic stacked_align_in, // Bit 9 of unstacked status word
  output logic stack_align_sel, // Current alignment selection
  output logic entry_pad, // Stack padded by one word at entry
  output logic stacked_align_bit, // Value to stack in status bit 9
  output logic return_pad, // Remove padding at return
  input wire logic dbus_fault, // Data bus fault from load or store
  input wire logic exec_pri_negative, // Running at priority -1 or -2
  output logic bus_fault_ignore, // Ignore bit
  output logic fault_ignored, // Fault dropped pulse
  output logic bus_fault_b_raise, // Fault passed on pulse
  output logic lockup, // Lock-up, held until reset
  input wire logic div_exec, // Divide instruction executes
  input wire logic divisor_zero, // Divisor is zero
  output logic div_zero_trap, // Divide trap bit
  output logic div_trap, // Divide trap pulse
  output logic div_zero_result, // Force quotient zero pulse
  input wire logic mem_access, // Load or store issued
  input wire logic [1:0] access_size, // Byte, half or word
  input wire logic [1:0] access_addr_lo, // Low address bits
  input wire logic multi_or_dword, // Multiple or doubleword transfer
  output logic unaligned_trap, // Unaligned trap bit
  output logic unaligned_fault, // Usage fault pulse
  input wire logic swtrig_write, // Software trigger register write
  input wire logic privileged, // Writer is privileged
  output logic unpriv_swtrig_access, // Access bit
  output logic swtrig_permit, // Write accepted pulse
  output logic swtrig_deny, // Write blocked pulse
  input wire logic thread_return_req, // Return requests thread mode
  input wire logic other_exc_active, // Other exceptions still active
  output logic thread_entry_any_level, // Thread entry bit
  output logic thread_ok, // Return to thread allowed pulse
  output logic thread_fault, // Return to thread refused pulse
  output logic [7:0] memfault_priority, // Memory management fault priority
  output logic [7:0] bus_fault_b_priority, // Bus fault priority
  output logic [7:0] usage_fault_a_priority, // Usage fault priority
  output logic [7:0] supervisor_call_priority, // Supervisor call priority
  output logic [7:0] pendable_service_priority, // Pendable service priority
  output logic [7:0] tick_priority // System tick priority
);

  ecpr_state_t s_q;
  ecpr_state_t s_d;

  function automatic ecpr_sel_t decode(input logic [11:0] addr);
    logic [11:0] word_addr;
    word_addr = {addr[11:2], 2'h0};
    if (word_addr == `ECPR_OFF_CONFIG_CONTROL) begin
      decode = ECPR_SEL_CONFIG_CONTROL;
    end else if (word_addr == `ECPR_OFF_HANDLER_PRIORITY_ONE) begin
      decode = ECPR_SEL_PRIORITY_ONE;
    end else if (word_addr == `ECPR_OFF_HANDLER_PRIORITY_TWO) begin
      decode = ECPR_SEL_PRIORITY_TWO;
    end else if (word_addr == `ECPR_OFF_HANDLER_PRIORITY_THREE) begin
      decode = ECPR_SEL_PRIORITY_THREE;
    end else begin
      decode = ECPR_SEL_NONE;
    end
  endfunction : decode

  // Keeps only the implemented upper bits of every priority byte
  function automatic logic [31:0] pri_mask();
    logic [7:0] byte_mask;
    byte_mask = 8'hFF << (`ECPR_PRI_FIELD_BITS - `ECPR_PRI_IMPL_BITS);
    pri_mask = {4{byte_mask}};
  endfunction : pri_mask

  // Byte-lane merge; reserved bits stay zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = ((old & ~lanes) | (wdata & lanes)) & mask;
  endfunction : merge

  function automatic logic misaligned(input logic [1:0] size, input logic [1:0] lo);
    if (size == `ECPR_SIZE_HALF) begin
      misaligned = lo[0];
    end else if (size == `ECPR_SIZE_WORD) begin
      misaligned = (lo != 2'h0);
    end else begin
      misaligned = 1'b0;
    end
  endfunction : misaligned

  logic setup;
  logic access;
  ecpr_sel_t sel;
  logic [31:0] cc;

  assign setup = psel & ~penable;
  assign access = psel & penable & s_q.pready;
  assign sel = decode(paddr);
  assign cc = s_q.config_control;

  always_comb begin
    s_d = s_q;
    s_d.entry_pad = 1'b0;
    s_d.return_pad = 1'b0;
    s_d.fault_ignored = 1'b0;
    s_d.bus_fault_b_raise = 1'b0;
    s_d.div_trap = 1'b0;
    s_d.div_zero_result = 1'b0;
    s_d.unaligned_fault = 1'b0;
    s_d.swtrig_permit = 1'b0;
    s_d.swtrig_deny = 1'b0;
    s_d.thread_ok = 1'b0;
    s_d.thread_fault = 1'b0;

    // Answer one cycle after setup so the read word can come from a flop
    s_d.pready = setup & ~s_q.pready;
    if (setup) begin
      s_d.pslverr = (sel == ECPR_SEL_NONE);
      s_d.prdata = 32'h00000000;
      if (!pwrite) begin
        unique case (sel)
          ECPR_SEL_CONFIG_CONTROL: s_d.prdata = cc;
          ECPR_SEL_PRIORITY_ONE: s_d.prdata = s_q.handler_priority_one;
          ECPR_SEL_PRIORITY_TWO: s_d.prdata = s_q.handler_priority_two;
          ECPR_SEL_PRIORITY_THREE: s_d.prdata = s_q.handler_priority_three;
          ECPR_SEL_NONE: s_d.prdata = 32'h00000000;
        endcase
      end
    end else if (!psel) begin
      s_d.pslverr = 1'b0;
    end

    if (access && pwrite) begin
      unique case (sel)
        ECPR_SEL_CONFIG_CONTROL: begin
          s_d.config_control = merge(cc, pwdata, pstrb, `ECPR_MASK_CONFIG_CONTROL);
        end
        ECPR_SEL_PRIORITY_ONE: begin
          s_d.handler_priority_one = merge(s_q.handler_priority_one, pwdata, pstrb,
                                           `ECPR_MASK_PRIORITY_ONE & pri_mask());
        end
        ECPR_SEL_PRIORITY_TWO: begin
          s_d.handler_priority_two = merge(s_q.handler_priority_two, pwdata, pstrb,
                                           `ECPR_MASK_PRIORITY_TWO & pri_mask());
        end
        ECPR_SEL_PRIORITY_THREE: begin
          s_d.handler_priority_three = merge(s_q.handler_priority_three, pwdata, pstrb,
                                             `ECPR_MASK_PRIORITY_THREE & pri_mask());
        end
        ECPR_SEL_NONE: begin
        end
      endcase
    end

    // Padding needed only when 8-byte alignment is selected and SP sits on an odd word
    if (exc_entry) begin
      s_d.entry_pad = cc[`ECPR_BIT_STACK_ALIGN] & entry_sp_bit2;
      s_d.stacked_align_bit = cc[`ECPR_BIT_STACK_ALIGN] & entry_sp_bit2;
    end
    // Return trusts the stacked bit, not the current setting, which may have changed
    if (exception_return_value) begin
      s_d.return_pad = stacked_align_in;
    end

    if (dbus_fault) begin
      if (exec_pri_negative && cc[`ECPR_BIT_BUS_FAULT_IGNORE]) begin
        s_d.fault_ignored = 1'b1;
      end else if (exec_pri_negative) begin
        s_d.lockup = 1'b1;
      end else begin
        s_d.bus_fault_b_raise = 1'b1;
      end
    end

    if (div_exec && divisor_zero) begin
      s_d.div_trap = cc[`ECPR_BIT_DIV_ZERO_TRAP];
      s_d.div_zero_result = ~cc[`ECPR_BIT_DIV_ZERO_TRAP];
    end

    if (mem_access) begin
      if (multi_or_dword) begin
        s_d.unaligned_fault = (access_addr_lo != 2'h0);
      end else begin
        s_d.unaligned_fault = cc[`ECPR_BIT_UNALIGNED_TRAP] &
                              misaligned(access_size, access_addr_lo);
      end
    end

    if (swtrig_write) begin
      s_d.swtrig_permit = privileged | cc[`ECPR_BIT_UNPRIV_SWTRIG];
      s_d.swtrig_deny = ~privileged & ~cc[`ECPR_BIT_UNPRIV_SWTRIG];
    end

    if (thread_return_req) begin
      s_d.thread_ok = ~other_exc_active | cc[`ECPR_BIT_THREAD_ANY_LEVEL];
      s_d.thread_fault = other_exc_active & ~cc[`ECPR_BIT_THREAD_ANY_LEVEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.config_control <= `ECPR_RST_CONFIG_CONTROL;
      s_q.handler_priority_one <= `ECPR_RST_PRIORITY;
      s_q.handler_priority_two <= `ECPR_RST_PRIORITY;
      s_q.handler_priority_three <= `ECPR_RST_PRIORITY;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign prdata = s_q.prdata;
  assign stack_align_sel = cc[`ECPR_BIT_STACK_ALIGN];
  assign entry_pad = s_q.entry_pad;
  assign stacked_align_bit = s_q.stacked_align_bit;
  assign return_pad = s_q.return_pad;
  assign bus_fault_ignore = cc[`ECPR_BIT_BUS_FAULT_IGNORE];
  assign fault_ignored = s_q.fault_ignored;
  assign bus_fault_b_raise = s_q.bus_fault_b_raise;
  assign lockup = s_q.lockup;
  assign div_zero_trap = cc[`ECPR_BIT_DIV_ZERO_TRAP];
  assign div_trap = s_q.div_trap;
  assign div_zero_result = s_q.div_zero_result;
  assign unaligned_trap = cc[`ECPR_BIT_UNALIGNED_TRAP];
  assign unaligned_fault = s_q.unaligned_fault;
  assign unpriv_swtrig_access = cc[`ECPR_BIT_UNPRIV_SWTRIG];
  assign swtrig_permit = s_q.swtrig_permit;
  assign swtrig_deny = s_q.swtrig_deny;
  assign thread_entry_any_level = cc[`ECPR_BIT_THREAD_ANY_LEVEL];
  assign thread_ok = s_q.thread_ok;
  assign thread_fault = s_q.thread_fault;
  assign memfault_priority = s_q.handler_priority_one[`ECPR_PRI_MEM_LSB +: `ECPR_PRI_FIELD_BITS];
  assign bus_fault_b_priority = s_q.handler_priority_one[`ECPR_PRI_BUS_LSB +: `ECPR_PRI_FIELD_BITS];
  assign usage_fault_a_priority =
    s_q.handler_priority_one[`ECPR_PRI_USAGE_LSB +: `ECPR_PRI_FIELD_BITS];
  assign supervisor_call_priority =
    s_q.handler_priority_two[`ECPR_PRI_SVC_LSB +: `ECPR_PRI_FIELD_BITS];
  assign pendable_service_priority =
    s_q.handler_priority_three[`ECPR_PRI_PEND_LSB +: `ECPR_PRI_FIELD_BITS];
  assign tick_priority = s_q.handler_priority_three[`ECPR_PRI_TICK_LSB +: `ECPR_PRI_FIELD_BITS];

endmodule : ecpr_regs

// ### ecpr_checker.sv
`timescale 1ns/10ps
module ecpr_checker (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // State frozen while low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic exc_entry, // Entry pulse
  input wire logic entry_sp_bit2, // Stack pointer bit 2
  input wire logic exception_return_value, // Return pulse
  input wire logic stacked_align_in, // Unstacked alignment bit
  input wire logic stack_align_sel, // Alignment select
  input wire logic entry_pad, // Entry padding pulse
  input wire logic return_pad, // Return padding pulse
  input wire logic dbus_fault, // Data bus fault
  input wire logic exec_pri_negative, // Negative priority
  input wire logic bus_fault_ignore, // Ignore bit
  input wire logic fault_ignored, // Fault dropped
  input wire logic bus_fault_b_raise, // Fault passed on
  input wire logic lockup, // Lock-up
  input wire logic div_exec, // Divide executes
  input wire logic divisor_zero, // Zero divisor
  input wire logic div_zero_trap, // Divide trap bit
  input wire logic div_trap, // Divide trap pulse
  input wire logic div_zero_result, // Zero quotient pulse
  input wire logic mem_access, // Load or store
  input wire logic multi_or_dword, // Multiple or doubleword
  input wire logic unaligned_fault, // Usage fault pulse
  input wire logic [1:0] access_addr_lo // Low address bits
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence cc_write_s;
    psel && penable && pready && pwrite && clk_en && paddr[11:2] == 10'h000 && pstrb[1];
  endsequence
  apb_answer_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("ready is not a one-cycle answer");
  align_write_a: assert property (
    cc_write_s |=> stack_align_sel == $past(pwdata[9]))
    else $error("alignment select not updated");
  reserved_zero_a: assert property (pready && !pwrite && !pslverr |-> (prdata &
    (paddr[3:2] == 2'h0 ? 32'hFFFFFCE4 : paddr[3:2] == 2'h1 ? 32'hFF000000 :
    paddr[3:2] == 2'h2 ? 32'h00FFFFFF : 32'h0000FFFF)) == 32'h0)
    else $error("reserved bits set");
  entry_pad_a: assert property (
    exc_entry && clk_en |=> entry_pad == $past(stack_align_sel && entry_sp_bit2))
    else $error("entry padding wrong");
  return_pad_a: assert property (
    exception_return_value && clk_en |=> return_pad == $past(stacked_align_in))
    else $error("return padding wrong");
  fault_ignore_a: assert property (
    dbus_fault && exec_pri_negative && bus_fault_ignore && clk_en
    |=> fault_ignored && !bus_fault_b_raise)
    else $error("fault not ignored");
  lockup_hold_a: assert property (
    dbus_fault && exec_pri_negative && !bus_fault_ignore && clk_en |=> lockup [*3])
    else $error("lock-up missing");
  div_zero_a: assert property (
    div_exec && divisor_zero && clk_en |=> div_trap == $past(div_zero_trap)
    && div_zero_result != $past(div_zero_trap))
    else $error("divide by zero outcome wrong");
  multi_fault_a: assert property (
    mem_access && multi_or_dword && access_addr_lo != 2'h0 && clk_en |=> unaligned_fault)
    else $error("unaligned multiple transfer not faulted");
endmodule : ecpr_checker

bind ecpr_regs ecpr_checker chk_u (.*);

// ### exception_config_priority_regs_tb.sv
`timescale 1ns/10ps
module exception_config_priority_regs_tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic exc_entry, entry_sp_bit2, exception_return_value, stacked_align_in, stack_align_sel, entry_pad;
  logic stacked_align_bit, return_pad, dbus_fault, exec_pri_negative, bus_fault_ignore;
  logic fault_ignored, bus_fault_b_raise, lockup, div_exec, divisor_zero, div_zero_trap, div_trap;
  logic div_zero_result, mem_access, multi_or_dword, unaligned_trap, unaligned_fault;
  logic [1:0] access_size, access_addr_lo;
  logic swtrig_write, privileged, unpriv_swtrig_access, swtrig_permit, swtrig_deny;
  logic thread_return_req, other_exc_active, thread_entry_any_level, thread_ok, thread_fault;
  logic [7:0] memfault_priority, bus_fault_b_priority, usage_fault_a_priority;
  logic [7:0] supervisor_call_priority, pendable_service_priority, tick_priority;
  logic [17:0] ev_in;
  logic [10:0] ev_out;
  int n_errors = 0;
  int n_tests = 0;
  logic [11:0] ta [9] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h004, 12'h00C, 12'h000,
    12'h010, 12'hFFC};
  logic [31:0] tw [9] = '{'1, '1, '1, '1, 32'h0, 32'h0, 32'h0, '1, '1};
  logic [3:0] ts [9] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h2, 4'h8, 4'hF, 4'hF, 4'hF};
  logic [31:0] te [9] = '{32'h0000031B, 32'h00FFFFFF, 32'hFF000000, 32'hFFFF0000, 32'h00FF00FF,
    32'h00FF0000, 32'h0, 32'h0, 32'h0};
  // Event rows: config value, core inputs, expected pulses
  logic [9:0] ec [5] = '{10'h200, 10'h31B, 10'h000, 10'h008, 10'h008};
  logic [17:0] ei [5] = '{18'h3EF4B, 18'h3BEAB, 18'h30B5E, 18'h002C0, 18'h00320};
  logic [10:0] eo [5] = '{11'h6A5, 11'h55A, 11'h01A, 11'h000, 11'h010};

  assign {exc_entry, entry_sp_bit2, exception_return_value, stacked_align_in, dbus_fault, exec_pri_negative,
    div_exec, divisor_zero, mem_access, access_size, access_addr_lo, multi_or_dword, swtrig_write,
    privileged, thread_return_req, other_exc_active} = ev_in;
  assign ev_out = {entry_pad, return_pad, fault_ignored, bus_fault_b_raise, div_trap, div_zero_result,
    unaligned_fault, swtrig_permit, swtrig_deny, thread_ok, thread_fault};

  ecpr_regs dut_u (.*);

  task results;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; returns one idle edge after the access completes
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so two calls in a row never assign psel twice in one time step
    @(posedge pclk);
  endtask : apb

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (3000) @(posedge pclk);
    n_errors++;
    results();
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ev_in = 18'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({stack_align_sel, memfault_priority, bus_fault_b_priority, usage_fault_a_priority,
      supervisor_call_priority, pendable_service_priority, tick_priority}, {1'b1, 48'h0});
    for (int i = 0; i < 9; i++) begin
      apb(ta[i], 1'b1, tw[i], ts[i]);
      chk({er, rd}, {ta[i][11:4] != 8'h00, 32'h0});
      apb(ta[i], 1'b0, 32'h0, 4'h0);
      chk({er, rd}, {ta[i][11:4] != 8'h00, te[i]});
    end
    apb(12'h004, 1'b1, 32'h44332211, 4'hF);
    apb(12'h008, 1'b1, 32'h55FFFFFF, 4'hF);
    apb(12'h00C, 1'b1, 32'h7766FFFF, 4'hF);
    @(negedge pclk);
    chk({usage_fault_a_priority, bus_fault_b_priority, memfault_priority}, 24'h332211);
    chk(supervisor_call_priority, 8'h55);
    chk({tick_priority, pendable_service_priority}, 16'h7766);
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(12'h000, 1'b1, {22'h0, ec[i]}, 4'hF);
      ev_in <= ei[i];
      @(posedge pclk);
      ev_in <= 18'h0;
      @(negedge pclk);
      chk(ev_out, eo[i]);
      chk(stacked_align_bit, eo[i][10]);
      chk({stack_align_sel, bus_fault_ignore, div_zero_trap, unaligned_trap, unpriv_swtrig_access,
        thread_entry_any_level}, {ec[i][9:8], ec[i][4:3], ec[i][1:0]});
      @(posedge pclk);
    end
    // Frozen clock enable: a return and a lock-up fault in that cycle must both be lost
    clk_en <= 1'b0;
    ev_in <= 18'h0F000;
    @(posedge pclk);
    clk_en <= 1'b1;
    ev_in <= 18'h0;
    @(negedge pclk);
    chk({return_pad, lockup}, 2'h0);
    @(posedge pclk);
    // Ignore bit is clear here, so a fault at negative priority must lock up and stay there
    ev_in <= 18'h03000;
    @(posedge pclk);
    ev_in <= 18'h0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk({lockup, bus_fault_b_raise}, 2'h2);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(lockup, 1'b0);
    @(posedge pclk);
    apb(12'h000, 1'b0, 32'h0, 4'h0);
    chk({er, rd}, 33'h000000200);
    results();
  end
endmodule : exception_config_priority_regs_tb
